// *** bench/fsc_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "fsc_map.vh"
// ****
// Port checker.
// ****
module fsc_chk (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [1:0] module_type,
    input wire logic fieldbus_activation_module,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic captured,
    input wire logic can_enable,
    input wire logic [1:0] can_baud,
    input wire logic [7:0] can_addr,
    input wire logic can_dupchk,
    input wire logic mod_enable,
    input wire logic [7:0] mod_addr,
    input wire logic drv_supply_en,
    input wire logic [7:0] rs485_cfg
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    chk_drv_follow: assert property (
        $past(rst_b) |-> drv_supply_en == $past(fieldbus_activation_module))
        else $error("supply lag");
    chk_cap_hold: assert property (
        $past(captured) |-> captured) else $error("capture dropped");
    chk_en_gate: assert property (
        !captured |-> !can_enable && !mod_enable) else $error("early on");
    chk_sw_hold: assert property (
        captured && $past(captured) && !$past(reg_wr, 2)
        |-> $stable({can_enable, can_baud, can_addr, mod_enable, mod_addr}))
        else $error("config moved");
    chk_mod_can_off: assert property (
        module_type != `FSC_MOD_NONE |-> !can_enable) else $error("can on");
    chk_param_rd: assert property (
        reg_rd && reg_addr == `FSC_REG_PARAM |=>
        reg_rdata[3] == can_dupchk && reg_rdata[31:24] == rs485_cfg)
        else $error("feature bits");
    chk_ovr_apply: assert property (
        captured && reg_wr && reg_addr == `FSC_REG_CTRL && reg_wdata[0]
        |-> ##2 (module_type == `FSC_MOD_NONE ? can_enable : mod_enable)
        == $past(reg_wdata[1], 2)) else $error("override");
    chk_rs485_hold: assert property (
        !$past(reg_wr, 2) |-> $stable(rs485_cfg)) else $error("rs485 moved");
    cov_eth: cover property (captured && module_type == 2'h2 && mod_enable);
    cov_clamp: cover property (can_enable && can_addr == 8'h1F);
    cov_ovr: cover property (reg_wr && reg_addr == 8'h00 && reg_wdata[0]);
endmodule // fsc_chk
`default_nettype wire

// *** bench/fsc_switch_bank.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****
// Switch bank.
// ****
module fsc_switch_bank (
    input wire logic clk_sys,
    input wire logic [7:0] set_pos,
    output logic [7:0] switch_in
);
    logic [7:0] last_q = 8'h00;
    logic [7:0] moved_q = 8'h00;
    logic [2:0] bounce_q = 3'h0;
    initial switch_in = 8'h00;
    // Moved contacts chatter, so one raw sample is never trustworthy.
    always @(posedge clk_sys) begin
        last_q <= set_pos;
        if (set_pos !== last_q) begin
            bounce_q <= 3'h4;
            moved_q <= set_pos ^ last_q;
        end else if (bounce_q != 3'h0) begin
            bounce_q <= bounce_q - 3'h1;
        end
        switch_in <= (bounce_q != 3'h0) ? switch_in ^ moved_q : set_pos;
    end
endmodule // fsc_switch_bank
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "fsc_map.vh"
// ****
// Bench: one reset per case.
// ****
module tb;
    logic clk_sys = 1'h0;
    logic rst_b = 1'h0;
    logic [7:0] set_pos = 8'h00;
    logic [1:0] module_type = 2'h0;
    logic fieldbus_activation_module = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic rd_pend = 1'h0;
    logic cfg_req = 1'h0;
    logic [31:0] reg_rdata, seed = 32'hC6F198A5;
    logic captured, can_enable, can_dupchk, mod_enable, drv_supply_en;
    logic [1:0] can_baud;
    logic [7:0] switch_in, can_addr, mod_addr, rs485_cfg;
    logic [63:0] exp_rd[$], exp_cfg[$];
    int errors = 0;
    int checked = 0;
    fsc_switch_bank u_bank (.clk_sys, .set_pos, .switch_in);
    fsc_top #(.SETTLE_CYC(2)) DUT (.clk_sys, .rst_b, .switch_in,
        .module_type, .fieldbus_activation_module, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .captured, .can_enable, .can_baud,
        .can_addr, .can_dupchk, .mod_enable, .mod_addr, .drv_supply_en,
        .rs485_cfg);
    initial forever #12.5 clk_sys = ~clk_sys;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [63:0] want(logic [1:0] t, logic [7:0] s,
        logic [31:0] q, logic [1:0] o);
        logic [31:0] e, m;
        int a;
        m = 32'h700200FF;
        e = {1'h0, fieldbus_activation_module, 1'h1, 11'h0, q[3], 9'h0,
            q[31:24]};
        if (t == 2'h0) begin
            m[27:18] = 10'h3FF;
            a = q[15:8] + s[4:0];
            e[28] = o[0] ? o[1] : (s != 8'h00 ? s[7] : q[0]);
            e[27:26] = s != 8'h00 ? s[6:5] : q[2:1];
            e[25:18] = s == 8'h00 ? q[15:8] : (a > 31 ? 8'h1F : 8'(a));
        end else begin
            a = q[15:8] + s[6:0];
            m[16] = s != 8'h00 || t == 2'h2 || o[0];
            e[16] = o[0] ? o[1] : (s == 8'h00 || s[7]);
            m[15:8] = (t == 2'h1 && s != 8'h00) ? 8'hFF : 8'h00;
            e[15:8] = a > 125 ? 8'h7D : (a < 3 ? 8'h03 : 8'(a));
        end
        return {m, e};
    endfunction
    task automatic cmp(input logic [31:0] g, input logic [63:0] me);
        checked++;
        if ((g & me[63:32]) !== (me[31:0] & me[63:32])) begin
            errors++;
            $display("ERROR %0t: got %h want %h", $time, g, me[31:0]);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_rd.push_back({32'hFFFFFFFF, e});
        @(posedge clk_sys);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
    endtask
    task automatic cfg(input logic [63:0] me);
        exp_cfg.push_back(me);
        @(posedge clk_sys);
        cfg_req <= 1'h1;
        @(posedge clk_sys);
        cfg_req <= 1'h0;
    endtask
    task automatic finish_test();
        if (errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys) rd_pend <= reg_rd;
    always @(negedge clk_sys) begin
        if (rd_pend) cmp(reg_rdata, exp_rd.pop_front());
        if (cfg_req) cmp({1'h0, drv_supply_en, captured, can_enable,
            can_baud, can_addr, can_dupchk, mod_enable, mod_addr,
            rs485_cfg}, exp_cfg.pop_front());
    end
    initial begin
        #100000;
        errors++;
        finish_test();
    end
    initial begin : main
        logic [31:0] r, p;
        logic [7:0] sw;
        logic [1:0] t;
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            p = rnd() & 32'hFF007F0F;
            t = i[1:0];
            sw = i[2] ? {~i[3], r[6:1], 1'h1} : 8'h00;
            rst_b <= 1'h0;
            set_pos <= sw;
            module_type <= t;
            fieldbus_activation_module <= r[31];
            repeat (16) @(posedge clk_sys);
            rst_b <= 1'h1;
            wr(`FSC_REG_PARAM, p);
            for (int n = 0; n < 40 && captured !== 1'h1; n++) @(posedge clk_sys);
            cfg(want(t, sw, p, 2'h0));
            set_pos <= rnd();
            fieldbus_activation_module <= r[30];
            repeat (8) @(posedge clk_sys);
            cfg(want(t, sw, p, 2'h0));
            wr(`FSC_REG_SWITCH, 32'hA5);
            rd(`FSC_REG_SWITCH, sw);
            rd(8'h20, 32'h0);
            rd(`FSC_REG_PARAM, p);
            wr(`FSC_REG_CTRL, r[29:28]);
            cfg(want(t, sw, p, r[29:28]));
            cfg(want(t, sw, p, r[29:28]));
        end
        finish_test();
    end
endmodule // tb
bind fsc_top fsc_chk u_chk (.clk_sys, .rst_b, .module_type,
    .fieldbus_activation_module, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .captured, .can_enable, .can_baud, .can_addr, .can_dupchk,
    .mod_enable, .mod_addr, .drv_supply_en, .rs485_cfg);
`default_nettype wire

// *** src/fsc_addr_clamp.v ***
`timescale 1ns/100ps
`default_nettype none
`include "fsc_map.vh"
module fsc_addr_clamp (
    input wire [7:0] base,
    input wire [6:0] offset,
    input wire serial_bus,
    output reg [7:0] addr
);
    reg [8:0] sum;

    always @* begin
        sum = {1'h0, base} + {2'h0, offset};
        if (serial_bus) begin
            if (sum < {1'h0, `FSC_SER_ADDR_MIN})
                addr = `FSC_SER_ADDR_MIN;
            else if (sum > {1'h0, `FSC_SER_ADDR_MAX})
                addr = `FSC_SER_ADDR_MAX;
            else
                addr = sum[7:0];
        end else begin
            if (sum > {1'h0, `FSC_CAN_ADDR_MAX})
                addr = `FSC_CAN_ADDR_MAX;
            else
                addr = sum[7:0];
        end
    end
endmodule // fsc_addr_clamp
`default_nettype wire

// *** src/fsc_map.vh ***
`ifndef FSC_MAP_VH
`define FSC_MAP_VH
// Register byte offsets.
`define FSC_REG_CTRL 8'h00
`define FSC_REG_SWITCH 8'h04
`define FSC_REG_STATUS 8'h08
`define FSC_REG_PARAM 8'h0C
`define FSC_REG_ADDR 8'h10
// Control register fields.
`define FSC_CTRL_OVR_VALID 0
`define FSC_CTRL_OVR_EN 1
// Parameter register fields.
`define FSC_PARAM_EN 0
`define FSC_PARAM_BAUD_LO 1
`define FSC_PARAM_DUPCHK 3
`define FSC_PARAM_BASE_LO 8
// Baud codes.
`define FSC_BAUD_1M 2'h3
`define FSC_BAUD_500K 2'h2
`define FSC_BAUD_250K 2'h1
`define FSC_BAUD_125K 2'h0
// Module type codes.
`define FSC_MOD_NONE 2'h0
`define FSC_MOD_SERIAL 2'h1
`define FSC_MOD_ETH 2'h2
`define FSC_MOD_OTHER 2'h3
// Address limits.
`define FSC_CAN_ADDR_MAX 8'h1F
`define FSC_SER_ADDR_MIN 8'h03
`define FSC_SER_ADDR_MAX 8'h7D
// Settling time after reset before the switch is captured.
`define FSC_SETTLE_NS 1000
`define FSC_CLK_NS 25
`define FSC_SETTLE_CYC ((`FSC_SETTLE_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`endif

// *** src/fsc_sync.v ***
`timescale 1ns/100ps
`default_nettype none
module fsc_sync #(
    parameter WIDTH = 8
) (
    input wire clk_sys,
    input wire rst_b,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= {WIDTH{1'h0}};
            sync_q <= {WIDTH{1'h0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule // fsc_sync
`default_nettype wire

// *** src/fsc_top.v ***
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "fsc_map.vh"
// Contract
// - Capture switch once after each reset
// - Later switch changes ignored until reset
// - All zero: use stored parameters
// - Nonzero switch overrides stored parameters
// - Position 8 enables communication
// - Two switch bits select CAN baud
// - Address is base plus switch value
// - Clamp address into bus range
// - No module: switch configures built-in CAN
// - Module fitted: CAN never switch-enabled
// - Ethernet, all zero: bus on
// - Ethernet, bits set, pos8 off: off
// - Software may re-enable bus later
// - Bus features come from stored parameters
// - Switch never configures RS485 interface
// - Driver supply needs activation module fitted
module fsc_top #(
    parameter SETTLE_CYC = `FSC_SETTLE_CYC
) (
    input wire clk_sys,
    input wire rst_b,
    input wire [7:0] switch_in,
    input wire [1:0] module_type,
    input wire fieldbus_activation_module,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    output reg captured,
    output reg can_enable,
    output reg [1:0] can_baud,
    output reg [7:0] can_addr,
    output reg can_dupchk,
    output reg mod_enable,
    output reg [7:0] mod_addr,
    output reg drv_supply_en,
    output reg [7:0] rs485_cfg
);
    // ************************************************************
    // Switch synchronisation and one-shot capture
    // ************************************************************
    localparam ST_SETTLE = 3'h1;
    localparam ST_CAPTURE = 3'h2;
    localparam ST_RUN = 3'h4;

    wire [7:0] sw_sync;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [15:0] cnt_q;
    reg [7:0] sw_q;
    reg [1:0] type_q;
    reg [31:0] param_q;
    reg [1:0] ctrl_q;

    fsc_sync #(.WIDTH(8)) u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .async_in(switch_in),
        .sync_out(sw_sync)
    );

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_SETTLE: begin
                if (cnt_q >= SETTLE_CYC[15:0])
                    state_d = ST_CAPTURE;
            end
            ST_CAPTURE: state_d = ST_RUN;
            ST_RUN: state_d = ST_RUN;
            default: state_d = ST_SETTLE;
        endcase
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_SETTLE;
            cnt_q <= 16'h0000;
            sw_q <= 8'h00;
            type_q <= `FSC_MOD_NONE;
        end else begin
            state_q <= state_d;
            if (state_q == ST_SETTLE)
                cnt_q <= cnt_q + 16'h0001;
            // The capture happens in one state only, so it is once per reset.
            if (state_q == ST_CAPTURE) begin
                sw_q <= sw_sync;
                type_q <= module_type;
            end
        end
    end

    // ************************************************************
    // Decoding
    // ************************************************************
    wire sw_zero = (sw_q == 8'h00);
    wire sw_en = sw_q[7];
    wire [1:0] sw_baud = sw_q[6:5];
    wire no_mod = (type_q == `FSC_MOD_NONE);
    wire is_ser = (type_q == `FSC_MOD_SERIAL);
    wire is_eth = (type_q == `FSC_MOD_ETH);
    wire [7:0] base = param_q[`FSC_PARAM_BASE_LO+7:`FSC_PARAM_BASE_LO];
    wire [7:0] can_addr_w;
    wire [7:0] ser_addr_w;
    reg can_en_d;
    reg mod_en_d;
    reg [1:0] baud_d;
    reg [7:0] can_addr_d;
    reg [7:0] mod_addr_d;

    fsc_addr_clamp u_can_clamp (
        .base(base),
        .offset({2'h0, sw_q[4:0]}),
        .serial_bus(1'h0),
        .addr(can_addr_w)
    );

    fsc_addr_clamp u_ser_clamp (
        .base(base),
        .offset(sw_q[6:0]),
        .serial_bus(1'h1),
        .addr(ser_addr_w)
    );

    always @* begin
        can_en_d = param_q[`FSC_PARAM_EN];
        baud_d = param_q[`FSC_PARAM_BAUD_LO+1:`FSC_PARAM_BAUD_LO];
        can_addr_d = base;
        mod_en_d = param_q[`FSC_PARAM_EN];
        mod_addr_d = base;
        if (no_mod) begin
            if (!sw_zero) begin
                can_en_d = sw_en;
                baud_d = sw_baud;
                can_addr_d = can_addr_w;
            end
        end else begin
            can_en_d = 1'h0;
            if (is_eth) begin
                mod_en_d = sw_zero ? 1'h1 : sw_en;
            end else if (!sw_zero) begin
                mod_en_d = sw_en;
                mod_addr_d = is_ser ? ser_addr_w : base;
            end
        end
        if (ctrl_q[`FSC_CTRL_OVR_VALID]) begin
            if (no_mod)
                can_en_d = ctrl_q[`FSC_CTRL_OVR_EN];
            else
                mod_en_d = ctrl_q[`FSC_CTRL_OVR_EN];
        end
    end

    // ************************************************************
    // Register port and registered outputs
    // ************************************************************
    wire running = (state_q == ST_RUN);

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            param_q <= 32'h00000000;
            ctrl_q <= 2'h0;
            reg_rdata <= 32'h00000000;
            captured <= 1'h0;
            can_enable <= 1'h0;
            can_baud <= `FSC_BAUD_125K;
            can_addr <= 8'h00;
            can_dupchk <= 1'h0;
            mod_enable <= 1'h0;
            mod_addr <= 8'h00;
            drv_supply_en <= 1'h0;
            rs485_cfg <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == `FSC_REG_CTRL)
                ctrl_q <= reg_wdata[1:0];
            if (reg_wr && reg_addr == `FSC_REG_PARAM)
                param_q <= reg_wdata;
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                case (reg_addr)
                    `FSC_REG_CTRL: reg_rdata <= {30'h0, ctrl_q};
                    `FSC_REG_SWITCH: reg_rdata <= {24'h0, sw_q};
                    `FSC_REG_STATUS: reg_rdata <= {24'h0, running,
                        drv_supply_en, type_q, mod_enable, can_enable,
                        can_baud};
                    `FSC_REG_PARAM: reg_rdata <= param_q;
                    `FSC_REG_ADDR: reg_rdata <= {16'h0, mod_addr, can_addr};
                    default: reg_rdata <= 32'h00000000;
                endcase
            end
            captured <= running;
            // Both enables stay off until the capture is done, so the bus
            // never starts on an unsettled switch value.
            can_enable <= running & can_en_d;
            can_baud <= baud_d;
            can_addr <= can_addr_d;
            can_dupchk <= param_q[`FSC_PARAM_DUPCHK];
            mod_enable <= running & mod_en_d;
            mod_addr <= mod_addr_d;
            drv_supply_en <= fieldbus_activation_module;
            rs485_cfg <= param_q[31:24];
        end
    end
endmodule // fsc_top
`default_nettype wire
